// file: include/video_route_pkg.sv
// Constants, field layouts and carrier types for the analog input routing block.
// Assumes a single system clock and a serial configuration port on the top.
package video_route_pkg;

  // Register offsets in the input/output map
  localparam logic [7:0] OFS_CONV01 = 8'hC3;
  localparam logic [7:0] OFS_MANUAL_CONV2 = 8'hC4;
  localparam logic [7:0] OFS_CONV3 = 8'hF3;
  localparam logic [7:0] OFS_FORMAT_SEL = 8'hE0;
  localparam logic [7:0] OFS_FORMAT_MODE = 8'hE1;

  // Field positions
  localparam int MANUAL_EN_BIT = 7;
  localparam int CONV0_LSB = 0;
  localparam int CONV1_LSB = 4;
  localparam int CONV2_LSB = 0;
  localparam int CONV3_LSB = 4;
  localparam int FMT_SEL_LSB = 0;
  localparam int SDPATH_LSB = 4;
  localparam int MODE_LSB = 0;
  localparam int STD_LSB = 4;

  // Reset values
  localparam logic [7:0] RST_CONV01 = 8'h00;
  localparam logic [7:0] RST_MANUAL_CONV2 = 8'h00;
  localparam logic [7:0] RST_CONV3 = 8'h00;
  localparam logic [7:0] RST_FORMAT_SEL = 8'h00;
  localparam logic [7:0] RST_FORMAT_MODE = 8'h00;

  // Implemented bits; the rest read as zero
  localparam logic [7:0] MASK_CONV01 = 8'hFF;
  localparam logic [7:0] MASK_MANUAL_CONV2 = 8'h8F;
  localparam logic [7:0] MASK_CONV3 = 8'hF0;
  localparam logic [7:0] MASK_FORMAT_SEL = 8'h3F;
  localparam logic [7:0] MASK_FORMAT_MODE = 8'hFF;

  // Routing selection codes
  localparam logic [3:0] CODE_IN1 = 4'h1;
  localparam logic [3:0] CODE_IN2 = 4'h2;
  localparam logic [3:0] CODE_IN3 = 4'hC;
  localparam logic [3:0] CODE_IN4 = 4'h4;
  localparam logic [3:0] CODE_IN5 = 4'h5;
  localparam logic [3:0] CODE_IN6 = 4'h6;

  localparam int NUM_CONV = 4;
  localparam int NUM_AIN = 6;

  // One switch bit per analog input pin, bit 0 is input 1
  typedef logic [NUM_AIN-1:0] ain_switch_t;
  typedef ain_switch_t [NUM_CONV-1:0] switch_bank_t;

  // Inputs each converter can physically reach
  localparam ain_switch_t CONV0_REACH = 6'h3F;
  localparam ain_switch_t CONV1_REACH = 6'h3C;
  localparam ain_switch_t CONV2_REACH = 6'h3A;
  localparam ain_switch_t CONV3_REACH = 6'h08;

  // Arbitrary serial device address
  localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h20;

  typedef struct packed {
    logic manual_route_enable;
    logic [3:0] route_sel;
  } route_cfg_t;

  typedef struct packed {
    logic [3:0] input_format_select;
    logic [1:0] sd_path_select;
    logic [3:0] core_mode_group;
    logic [3:0] video_standard_code;
  } format_cfg_t;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_ADDR = 4'h1,
    ST_ACK_ADDR = 4'h2,
    ST_SUB = 4'h3,
    ST_ACK_SUB = 4'h4,
    ST_WDATA = 4'h5,
    ST_ACK_WDATA = 4'h6,
    ST_RDATA = 4'h7,
    ST_RACK = 4'h8
  } serial_state_t;

endpackage : video_route_pkg

// file: rtl/pin_sync.sv
// Two-flop synchronisers for the serial configuration pins.
// Assumes inputs arrive asynchronously to sys_clk.
`timescale 1ns/1ns
module pin_sync (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [1:0] pin_i,
  output logic [1:0] pin_q
);
  logic [1:0] meta_q;

  genvar i;
  generate
    for (i = 0; i < 2; i++) begin : g_bit
      always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
          meta_q[i] <= 1'b1;
          pin_q[i] <= 1'b1;
        end else begin
          meta_q[i] <= pin_i[i];
          pin_q[i] <= meta_q[i];
        end
      end
    end
  endgenerate
endmodule : pin_sync

// file: rtl/route_switch.sv
// Decodes one converter's routing selection into analog switch enables.
// Assumes the configuration comes from registers on the same clock.
`timescale 1ns/1ns
module route_switch #(
  parameter video_route_pkg::ain_switch_t REACH = video_route_pkg::CONV0_REACH
) (
  input wire logic sys_clk,
  input wire logic rst,
  input video_route_pkg::route_cfg_t cfg,
  output video_route_pkg::ain_switch_t sw_q
);
  import video_route_pkg::*;

  ain_switch_t code_hit;
  ain_switch_t sw_d;

  always_comb begin
    code_hit = '0;
    unique case (cfg.route_sel)
      CODE_IN1: code_hit = 6'h01;
      CODE_IN2: code_hit = 6'h02;
      CODE_IN3: code_hit = 6'h04;
      CODE_IN4: code_hit = 6'h08;
      CODE_IN5: code_hit = 6'h10;
      CODE_IN6: code_hit = 6'h20;
      default: code_hit = 6'h00;
    endcase
    sw_d = cfg.manual_route_enable ? (code_hit & REACH) : 6'h00;
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sw_q <= 6'h00;
    end else begin
      sw_q <= sw_d;
    end
  end
endmodule : route_switch

// file: rtl/video_input_route_control.sv
// Analog input routing configuration: serial register port, register file
// and the four converter switch decoders.
// Assumes an external pull-up on the data line and scl/sda from pins.
//
// Behaviour
// - Converters are routed only by manual control; switches stay open until enable is set.
// - Manual routing enable lives in bit 7 of register C4.
// - Routing touches only switches; format fields are programmed separately.
// - Converter 0 selection lives in bits 3 to 0 of register C3.
// - Converter 1 selection lives in bits 7 to 4 of register C3.
// - Converter 2 selection lives in bits 3 to 0 of register C4.
// - Converter 3 selection lives in bits 7 to 4 of register F3.
// - Converter 0 reaches inputs 1, 2, 4, 5, 6 and 3 by code.
// - Converter 1 reaches inputs 4, 5, 6, 3; codes 0001, 0010 unconnected.
// - Converter 2 reaches inputs 2, 4, 5, 6; codes 0001, 1100 unconnected.
// - Converter 3 reaches input 4 only, with code 0100.
`timescale 1ns/1ns
module video_input_route_control #(
  parameter logic [6:0] DEV_ADDR = video_route_pkg::DEV_ADDR_DEFAULT
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  output video_route_pkg::switch_bank_t conv_switch,
  output logic manual_route_enable,
  output video_route_pkg::format_cfg_t format_cfg
);
  import video_route_pkg::*;

  // Pin synchronisation
  logic [1:0] pins_s;
  logic scl_s;
  logic sda_s;
  logic scl_prev_q;
  logic sda_prev_q;

  pin_sync u_sync (
    .sys_clk(sys_clk),
    .rst(rst),
    .pin_i({scl_i, sda_i}),
    .pin_q(pins_s)
  );

  assign scl_s = pins_s[1];
  assign sda_s = pins_s[0];

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
    end else begin
      scl_prev_q <= scl_s;
      sda_prev_q <= sda_s;
    end
  end

  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;

  assign scl_rise = scl_s & ~scl_prev_q;
  assign scl_fall = ~scl_s & scl_prev_q;
  assign bus_start = scl_s & scl_prev_q & sda_prev_q & ~sda_s;
  assign bus_stop = scl_s & scl_prev_q & ~sda_prev_q & sda_s;

  // Register file
  logic [7:0] conv01_q;
  logic [7:0] conv01_d;
  logic [7:0] manual_conv2_q;
  logic [7:0] manual_conv2_d;
  logic [7:0] conv3_q;
  logic [7:0] conv3_d;
  logic [7:0] format_sel_q;
  logic [7:0] format_sel_d;
  logic [7:0] format_mode_q;
  logic [7:0] format_mode_d;

  logic reg_wr;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;

  always_comb begin
    conv01_d = conv01_q;
    manual_conv2_d = manual_conv2_q;
    conv3_d = conv3_q;
    format_sel_d = format_sel_q;
    format_mode_d = format_mode_q;
    if (reg_wr) begin
      unique case (reg_addr)
        OFS_CONV01: conv01_d = reg_wdata & MASK_CONV01;
        OFS_MANUAL_CONV2: manual_conv2_d = reg_wdata & MASK_MANUAL_CONV2;
        OFS_CONV3: conv3_d = reg_wdata & MASK_CONV3;
        OFS_FORMAT_SEL: format_sel_d = reg_wdata & MASK_FORMAT_SEL;
        OFS_FORMAT_MODE: format_mode_d = reg_wdata & MASK_FORMAT_MODE;
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      conv01_q <= RST_CONV01;
      manual_conv2_q <= RST_MANUAL_CONV2;
      conv3_q <= RST_CONV3;
      format_sel_q <= RST_FORMAT_SEL;
      format_mode_q <= RST_FORMAT_MODE;
    end else begin
      conv01_q <= conv01_d;
      manual_conv2_q <= manual_conv2_d;
      conv3_q <= conv3_d;
      format_sel_q <= format_sel_d;
      format_mode_q <= format_mode_d;
    end
  end

  // Read-back; unmapped offsets read zero
  always_comb begin
    unique case (reg_addr)
      OFS_CONV01: reg_rdata = conv01_q;
      OFS_MANUAL_CONV2: reg_rdata = manual_conv2_q;
      OFS_CONV3: reg_rdata = conv3_q;
      OFS_FORMAT_SEL: reg_rdata = format_sel_q;
      OFS_FORMAT_MODE: reg_rdata = format_mode_q;
      default: reg_rdata = 8'h00;
    endcase
  end

  // Format fields go downstream untouched by routing
  always_comb begin
    format_cfg.input_format_select = format_sel_q[FMT_SEL_LSB +: 4];
    format_cfg.sd_path_select = format_sel_q[SDPATH_LSB +: 2];
    format_cfg.core_mode_group = format_mode_q[MODE_LSB +: 4];
    format_cfg.video_standard_code = format_mode_q[STD_LSB +: 4];
  end

  assign manual_route_enable = manual_conv2_q[MANUAL_EN_BIT];

  // Converter switch decoders
  route_cfg_t conv_cfg [NUM_CONV];
  logic [3:0] conv_sel [NUM_CONV];
  localparam ain_switch_t REACH_TAB [NUM_CONV] = '{CONV0_REACH, CONV1_REACH,
                                                   CONV2_REACH, CONV3_REACH};

  assign conv_sel[0] = conv01_q[CONV0_LSB +: 4];
  assign conv_sel[1] = conv01_q[CONV1_LSB +: 4];
  assign conv_sel[2] = manual_conv2_q[CONV2_LSB +: 4];
  assign conv_sel[3] = conv3_q[CONV3_LSB +: 4];

  genvar c;
  generate
    for (c = 0; c < NUM_CONV; c++) begin : g_conv
      assign conv_cfg[c].manual_route_enable = manual_route_enable;
      assign conv_cfg[c].route_sel = conv_sel[c];
      route_switch #(
        .REACH(REACH_TAB[c])
      ) u_switch (
        .sys_clk(sys_clk),
        .rst(rst),
        .cfg(conv_cfg[c]),
        .sw_q(conv_switch[c])
      );
    end
  endgenerate

  // Serial configuration port
  serial_state_t state_q;
  serial_state_t state_d;
  logic [7:0] shift_q;
  logic [7:0] shift_d;
  logic [2:0] bit_idx_q;
  logic [2:0] bit_idx_d;
  logic full_q;
  logic full_d;
  logic [7:0] ptr_q;
  logic [7:0] ptr_d;
  logic drive_q;
  logic drive_d;

  assign reg_addr = ptr_q;
  assign reg_wdata = shift_q;
  assign sda_o = 1'b0;
  assign sda_oe = drive_q;

  always_comb begin
    state_d = state_q;
    shift_d = shift_q;
    bit_idx_d = bit_idx_q;
    full_d = full_q;
    ptr_d = ptr_q;
    drive_d = drive_q;
    reg_wr = 1'b0;
    if (bus_start) begin
      state_d = ST_ADDR;
      bit_idx_d = 3'h0;
      full_d = 1'b0;
      drive_d = 1'b0;
    end else if (bus_stop) begin
      state_d = ST_IDLE;
      drive_d = 1'b0;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          drive_d = 1'b0;
        end
        ST_ADDR, ST_SUB, ST_WDATA: begin
          if (scl_rise && !full_q) begin
            shift_d = {shift_q[6:0], sda_s};
            bit_idx_d = bit_idx_q + 3'h1;
            full_d = (bit_idx_q == 3'h7);
          end else if (scl_fall && full_q) begin
            full_d = 1'b0;
            bit_idx_d = 3'h0;
            if (state_q == ST_ADDR) begin
              if (shift_q[7:1] == DEV_ADDR) begin
                state_d = ST_ACK_ADDR;
                drive_d = 1'b1;
              end else begin
                state_d = ST_IDLE;
              end
            end else if (state_q == ST_SUB) begin
              ptr_d = shift_q;
              state_d = ST_ACK_SUB;
              drive_d = 1'b1;
            end else begin
              reg_wr = 1'b1;
              state_d = ST_ACK_WDATA;
              drive_d = 1'b1;
            end
          end
        end
        ST_ACK_ADDR: begin
          if (scl_fall) begin
            if (shift_q[0]) begin
              shift_d = reg_rdata;
              drive_d = ~reg_rdata[7];
              bit_idx_d = 3'h0;
              state_d = ST_RDATA;
            end else begin
              drive_d = 1'b0;
              state_d = ST_SUB;
            end
          end
        end
        ST_ACK_SUB: begin
          if (scl_fall) begin
            drive_d = 1'b0;
            state_d = ST_WDATA;
          end
        end
        ST_ACK_WDATA: begin
          if (scl_fall) begin
            drive_d = 1'b0;
            ptr_d = ptr_q + 8'h01;
            state_d = ST_WDATA;
          end
        end
        ST_RDATA: begin
          if (scl_fall) begin
            if (bit_idx_q == 3'h7) begin
              drive_d = 1'b0;
              state_d = ST_RACK;
            end else begin
              shift_d = {shift_q[6:0], 1'b0};
              drive_d = ~shift_q[6];
              bit_idx_d = bit_idx_q + 3'h1;
            end
          end
        end
        ST_RACK: begin
          if (scl_rise) begin
            if (sda_s) begin
              state_d = ST_IDLE;
            end else begin
              ptr_d = ptr_q + 8'h01;
            end
          end else if (scl_fall) begin
            shift_d = reg_rdata;
            drive_d = ~reg_rdata[7];
            bit_idx_d = 3'h0;
            state_d = ST_RDATA;
          end
        end
        default: begin
          state_d = ST_IDLE;
          drive_d = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_q <= ST_IDLE;
      shift_q <= 8'h00;
      bit_idx_q <= 3'h0;
      full_q <= 1'b0;
      ptr_q <= 8'h00;
      drive_q <= 1'b0;
    end else begin
      state_q <= state_d;
      shift_q <= shift_d;
      bit_idx_q <= bit_idx_d;
      full_q <= full_d;
      ptr_q <= ptr_d;
      drive_q <= drive_d;
    end
  end

endmodule : video_input_route_control

// file: bench/video_input_route_control_sva.sv
// Port assertions for the analog input routing block.
// Assumes binding onto video_input_route_control, one clock domain.
`timescale 1ns/1ns
module video_input_route_control_sva (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe,
  input video_route_pkg::switch_bank_t conv_switch,
  input wire logic manual_route_enable,
  input video_route_pkg::format_cfg_t format_cfg
);
  import video_route_pkg::*;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  property p_route_off;
    !manual_route_enable && !$past(manual_route_enable) |-> conv_switch == '0;
  endproperty
  a_route_off: assert property (p_route_off) else $error("switch closed while disabled");
  property p_route_needs_enable;
    $changed(conv_switch) |-> $past(manual_route_enable) || $past(manual_route_enable, 2);
  endproperty
  a_route_needs_enable: assert property (p_route_needs_enable) else $error("switch moved");
  property p_one_input;
    $onehot0(conv_switch[0]) && $onehot0(conv_switch[1]) && $onehot0(conv_switch[2])
      && $onehot0(conv_switch[3]);
  endproperty
  a_one_input: assert property (p_one_input) else $error("two inputs on one converter");
  property p_conv1_reach;
    conv_switch[1][1:0] == 2'h0;
  endproperty
  a_conv1_reach: assert property (p_conv1_reach) else $error("converter 1 on input 1 or 2");
  property p_conv2_reach;
    conv_switch[2][0] == 1'b0 && conv_switch[2][2] == 1'b0;
  endproperty
  a_conv2_reach: assert property (p_conv2_reach) else $error("converter 2 on input 1 or 3");
  property p_conv3_reach;
    (conv_switch[3] & 6'h37) == 6'h00;
  endproperty
  a_conv3_reach: assert property (p_conv3_reach) else $error("converter 3 off input 4");
  property p_format_apart;
    $changed(format_cfg) |=> $stable(conv_switch) [*2];
  endproperty
  a_format_apart: assert property (p_format_apart) else $error("format moved switches");
  property p_enable_on_low;
    $changed(manual_route_enable) |-> !scl_i && $stable(format_cfg);
  endproperty
  a_enable_on_low: assert property (p_enable_on_low) else $error("enable moved badly");
endmodule : video_input_route_control_sva
bind video_input_route_control video_input_route_control_sva i_video_input_route_control_sva (
  .sys_clk(sys_clk), .rst(rst), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe),
  .conv_switch(conv_switch), .manual_route_enable(manual_route_enable), .format_cfg(format_cfg)
);

// file: bench/host_model.sv
// Serial configuration host: writes and reads registers of the routing block.
// Assumes a pulled-up data line resolved by the bench; scl stands high when idle.
`timescale 1ns/1ns
module host_model #(
  parameter logic [6:0] DEV_ADDR = video_route_pkg::DEV_ADDR_DEFAULT
) (
  input wire logic sys_clk,
  input wire logic sda,
  output logic scl,
  output logic sda_low,
  output logic nack
);
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
    nack = 1'b0;
  end
  task automatic ph();
    repeat (5) @(posedge sys_clk);
    #1;
  endtask : ph
  task automatic start();
    ph();
    sda_low = 1'b0;
    ph();
    scl = 1'b1;
    ph();
    sda_low = 1'b1;
    ph();
    scl = 1'b0;
  endtask : start
  task automatic stop();
    ph();
    sda_low = 1'b1;
    ph();
    scl = 1'b1;
    ph();
    sda_low = 1'b0;
    ph();
  endtask : stop
  task automatic bit_io(input logic b, output logic r);
    ph();
    sda_low = !b;
    ph();
    scl = 1'b1;
    ph();
    r = sda;
    scl = 1'b0;
  endtask : bit_io
  task automatic byte_out(input logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r);
    end
    bit_io(1'b1, r);
    nack = nack | r;
  endtask : byte_out
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
    start();
    byte_out({DEV_ADDR, 1'b0});
    byte_out(a);
    byte_out(d);
    stop();
  endtask : write_reg
  task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
    logic r;
    start();
    byte_out({DEV_ADDR, 1'b0});
    byte_out(a);
    start();
    byte_out({DEV_ADDR, 1'b1});
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, d[i]);
    end
    bit_io(1'b1, r);
    stop();
  endtask : read_reg
  task automatic write_two(input logic [7:0] a, input logic [7:0] d0, input logic [7:0] d1);
    start();
    byte_out({DEV_ADDR, 1'b0});
    byte_out(a);
    byte_out(d0);
    byte_out(d1);
    stop();
  endtask : write_two
  task automatic read_two(input logic [7:0] a, output logic [7:0] d0, output logic [7:0] d1);
    logic r;
    start();
    byte_out({DEV_ADDR, 1'b0});
    byte_out(a);
    start();
    byte_out({DEV_ADDR, 1'b1});
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, d0[i]);
    end
    bit_io(1'b0, r);
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, d1[i]);
    end
    bit_io(1'b1, r);
    stop();
  endtask : read_two
endmodule : host_model

// file: bench/video_input_route_control_bench.sv
// Self-checking bench for the analog input routing block.
// Assumes the host model drives the serial pins; data line has a pull-up.
`timescale 1ns/1ns
module video_input_route_control_bench;
  import video_route_pkg::*;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic scl, sda_low, sda_i, sda_o, sda_oe, manual_route_enable, nack;
  switch_bank_t conv_switch;
  format_cfg_t format_cfg;
  logic [7:0] rd;
  int num_errors = 0;
  int checks = 0;
  always #5 sys_clk = ~sys_clk;
  assign sda_i = ~(sda_low | (sda_oe & ~sda_o));
  video_input_route_control i_video_input_route_control (.sys_clk(sys_clk), .rst(rst),
    .scl_i(scl), .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe), .conv_switch(conv_switch),
    .manual_route_enable(manual_route_enable), .format_cfg(format_cfg));
  host_model i_host_model (.sys_clk(sys_clk), .sda(sda_i), .scl(scl), .sda_low(sda_low),
    .nack(nack));
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : check
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    i_host_model.read_reg(a, rd);
    check({24'h0, rd}, {24'h0, exp});
  endtask : rd_chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    i_host_model.write_reg(a, d);
    repeat (2) @(posedge sys_clk);
    #1;
  endtask : wr
  function automatic ain_switch_t exp_sw(input int c, input logic [3:0] code);
    ain_switch_t reach [4] = '{6'h3F, 6'h3C, 6'h3A, 6'h08};
    ain_switch_t s;
    case (code)
      4'h1: s = 6'h01;
      4'h2: s = 6'h02;
      4'hC: s = 6'h04;
      4'h4: s = 6'h08;
      4'h5: s = 6'h10;
      4'h6: s = 6'h20;
      default: s = 6'h00;
    endcase
    return s & reach[c];
  endfunction : exp_sw
  task automatic t_reset();
    check({8'h0, conv_switch}, 32'h0);
    check({17'h0, manual_route_enable, format_cfg}, 32'h0);
    rd_chk(8'hC3, 8'h00);
    rd_chk(8'hC4, 8'h00);
    rd_chk(8'hF3, 8'h00);
    $display("reset test done");
  endtask : t_reset
  task automatic t_disabled();
    wr(8'hC3, 8'h54);
    wr(8'hC4, 8'h06);
    check({8'h0, conv_switch}, 32'h0);
    rd_chk(8'hC3, 8'h54);
    rd_chk(8'hC4, 8'h06);
    wr(8'hC4, 8'h86);
    check({8'h0, conv_switch}, {8'h0, 6'h00, 6'h20, 6'h10, 6'h08});
    $display("disabled test done");
  endtask : t_disabled
  task automatic t_table();
    logic [3:0] codes [9] = '{4'h1, 4'h2, 4'hC, 4'h4, 4'h5, 4'h6, 4'h0, 4'h3, 4'hF};
    for (int i = 0; i < 9; i++) begin
      wr(8'hC3, {codes[i], codes[i]});
      wr(8'hC4, {4'h8, codes[i]});
      wr(8'hF3, {codes[i], 4'h0});
      for (int c = 0; c < 4; c++) begin
        check({26'h0, conv_switch[c]}, {26'h0, exp_sw(c, codes[i])});
      end
    end
    wr(8'hC4, 8'h04);
    check({8'h0, conv_switch}, 32'h0);
    $display("table test done");
  endtask : t_table
  task automatic t_masks();
    wr(8'hC4, 8'hFF);
    rd_chk(8'hC4, 8'h8F);
    wr(8'hF3, 8'hFF);
    rd_chk(8'hF3, 8'hF0);
    wr(8'h10, 8'h5A);
    rd_chk(8'h10, 8'h00);
    $display("mask test done");
  endtask : t_masks
  task automatic t_format();
    logic [13:0] rec [5] = '{14'h0002, 14'h0302, 14'h2402, 14'h000A, 14'h001C};
    wr(8'hC3, 8'h56);
    wr(8'hC4, 8'h84);
    check({8'h0, conv_switch}, {8'h0, 6'h00, 6'h08, 6'h10, 6'h20});
    for (int i = 0; i < 5; i++) begin
      wr(8'hE0, {2'b00, rec[i][9:8], rec[i][13:10]});
      wr(8'hE1, {rec[i][3:0], rec[i][7:4]});
      check({18'h0, format_cfg}, {18'h0, rec[i]});
      check({8'h0, conv_switch}, {8'h0, 6'h00, 6'h08, 6'h10, 6'h20});
    end
    $display("format test done");
  endtask : t_format
  task automatic t_burst();
    logic [7:0] d0, d1;
    i_host_model.write_two(8'hC3, 8'h4C, 8'h82);
    repeat (2) @(posedge sys_clk);
    #1;
    check({8'h0, conv_switch}, {8'h0, 6'h00, 6'h02, 6'h08, 6'h04});
    i_host_model.read_two(8'hC3, d0, d1);
    check({24'h0, d0}, 32'h0000004C);
    check({24'h0, d1}, 32'h00000082);
    $display("burst test done");
  endtask : t_burst
  task automatic stop_test();
    $display("comparisons %0d, mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : stop_test
  initial begin
    #500000;
    num_errors++;
    stop_test();
  end
  initial begin
    repeat (2) @(posedge sys_clk);
    #1;
    rst = 1'b0;
    repeat (3) @(posedge sys_clk);
    #1;
    t_reset();
    t_disabled();
    t_table();
    t_masks();
    t_format();
    t_burst();
    check({31'h0, nack}, 32'h0);
    stop_test();
  end
endmodule : video_input_route_control_bench
